// file: src/qtc_pkg.sv
package qtc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_PAGE_TIMER = 8'h00;
  localparam logic [7:0] ADDR_T0_UPPER  = 8'h8C;
  localparam logic [7:0] ADDR_T1_UPPER  = 8'h8D;
  localparam logic [7:0] RST_UPPER      = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Clock dividers, in system clock cycles or source events
  // ----------------------------------------------------------------
  localparam int unsigned DIV_SYS12 = 12;
  localparam int unsigned DIV_SYS4  = 4;
  localparam int unsigned DIV_SYS48 = 48;
  localparam int unsigned DIV_ALT8  = 8;

  // ----------------------------------------------------------------
  // Overflow and capture flag positions
  // ----------------------------------------------------------------
  localparam int unsigned FLG_T0     = 0;
  localparam int unsigned FLG_T1     = 1;
  localparam int unsigned FLG_T23_LO = 2;  // Plus 2 * timer index.
  localparam int unsigned FLG_T23_HI = 3;  // Plus 2 * timer index.
  localparam int unsigned FLG_CAP    = 6;  // Plus timer index.

  // ----------------------------------------------------------------
  // Modes and clock choices
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    T01_MODE_13BIT, T01_MODE_16BIT, T01_MODE_8BIT_RELOAD, T01_MODE_SPLIT
  } qtc_t01_mode_e;

  typedef enum logic [1:0] {
    T23_SYS_DIV12, T23_SYS, T23_ALT_DIV8, T23_COMP
  } qtc_t23_clk_e;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } qtc_sfr_req_s;

  typedef struct packed {
    logic          run;
    logic          counter_mode;
    logic          source_select;  // High picks the undivided system clock.
    qtc_t01_mode_e mode;
  } qtc_t01_cfg_s;

  typedef struct packed {
    logic         run;
    logic         split;
    logic         capture;
    qtc_t23_clk_e clk_sel;
  } qtc_t23_cfg_s;

  typedef struct packed {
    logic [1:0][15:0] t01;
    logic [1:0][15:0] t23;
    logic [1:0][15:0] cap;
    logic [7:0]       flag;
    logic [1:0]       pin_smp;
    logic [1:0]       pin_prev;
    logic [1:0]       cmp_prev;
    logic [7:0]       rdata;
  } qtc_state_s;

endpackage

// file: src/qtc_div.sv
`timescale 1ns/1ns
// Divides a stream of one-cycle input events by DIV, one pulse out per DIV in.
module qtc_div #(
  parameter int unsigned DIV = 12
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic in_tick_i,
  output logic      tick_o
);
  import qtc_pkg::*;

  localparam int unsigned W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } qtc_div_state_s;

  qtc_div_state_s st_ff;
  qtc_div_state_s nxt_st;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // The output pulse is registered, so it lags the last input event by one cycle.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (in_tick_i) begin
      if (st_ff.cnt == LAST) begin
        nxt_st.cnt  = '0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

// file: src/qtc_timers.sv
`timescale 1ns/1ns
// Operation
// - Timers 0 and 1 offer 13-bit, 16-bit and 8-bit auto-reload modes.
// - Only timer 0 splits into two 8-bit counters; timer 1 holds in that mode.
// - Timers 2 and 3 run 16-bit auto-reload or two 8-bit auto-reload halves.
// - Timers 2 and 3 capture their count on a selected source event.
// - Timers 0 and 1 clock from five sources using source select and scale bits.
// - Each of timers 0 and 1 picks prescaled clock or system clock.
// - Timers 2 and 3 clock from system clock or system clock divided by twelve.
// - Timer 2 also clocks from real-time clock divided by eight or comparator A.
// - Timer 3 also clocks from external oscillator divided by eight or comparator B.
// - In counter mode timers 0 and 1 count falling edges on their event pin.
// - Event edges up to a quarter of system clock rate are all counted.
// - Timers measure intervals, count events and flag overflows periodically.
// - Timer 0 upper byte is read/write at page 0, address 0x8C, reset zero.
// - Timer 1 upper byte is read/write at page 0, address 0x8D, reset zero.
module qtc_timers (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire qtc_pkg::qtc_sfr_req_s sfr_req_i,
  output logic [7:0]                sfr_rdata_o,
  input  wire qtc_pkg::qtc_t01_cfg_s timer_zero_cfg_i,
  input  wire qtc_pkg::qtc_t01_cfg_s timer_one_cfg_i,
  input  wire logic                 prescale_select_high_i,
  input  wire logic                 prescale_select_low_i,
  input  wire logic                 timer_zero_event_pin_i,
  input  wire logic                 timer_one_event_pin_i,
  input  wire qtc_pkg::qtc_t23_cfg_s timer_two_cfg_i,
  input  wire qtc_pkg::qtc_t23_cfg_s timer_three_cfg_i,
  input  wire logic [1:0][15:0]     t23_reload_i,
  input  wire logic                 rtc_tick_i,
  input  wire logic                 ext_osc_tick_i,
  input  wire logic                 comparator_a_output_i,
  input  wire logic                 comparator_b_output_i,
  input  wire logic [7:0]           flag_clear_i,
  output logic [7:0]                flag_o,
  output logic [1:0][15:0]          t01_count_o,
  output logic [1:0][15:0]          t23_count_o,
  output logic [1:0][15:0]          t23_capture_o
);
  import qtc_pkg::*;

  qtc_state_s   st_ff;
  qtc_state_s   nxt_st;
  logic         sys12_tick;
  logic         sys4_tick;
  logic         sys48_tick;
  logic         ext8_tick;
  logic         rtc8_tick;
  logic         pre_tick;
  logic [1:0]   fall;
  logic [1:0]   cmp_rise;
  logic [1:0]   t01_tick;
  logic [1:0]   t01_tmr_tick;
  logic [1:0]   wr_upper;
  qtc_t01_cfg_s t01_cfg [2];
  qtc_t23_cfg_s t23_cfg [2];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One counting step of timer 0 or 1; bit 16 is the overflow.
  function automatic logic [16:0] t01_step(input qtc_t01_mode_e m, input logic [15:0] c);
    logic [12:0] n13;
    n13 = {c[15:8], c[4:0]} + 13'h0001;
    case (m)
      T01_MODE_13BIT:       t01_step = {&{c[15:8], c[4:0]}, n13[12:5], c[7:5], n13[4:0]};
      T01_MODE_16BIT:       t01_step = {&c, c + 16'h0001};
      T01_MODE_8BIT_RELOAD: t01_step = {&c[7:0], c[15:8], (&c[7:0]) ? c[15:8] : c[7:0] + 8'h01};
      T01_MODE_SPLIT:       t01_step = {&c[7:0], c[15:8], c[7:0] + 8'h01};
      default:              t01_step = {1'b0, c};
    endcase
  endfunction

  // An 8-bit auto-reload step; bit 8 is the overflow.
  function automatic logic [8:0] ar8(input logic [7:0] c, input logic [7:0] rl);
    ar8 = {&c, (&c) ? rl : c + 8'h01};
  endfunction

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  qtc_div #(.DIV(DIV_SYS12)) u_sys12 (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .in_tick_i(1'b1), .tick_o(sys12_tick));
  qtc_div #(.DIV(DIV_SYS4)) u_sys4 (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .in_tick_i(1'b1), .tick_o(sys4_tick));
  qtc_div #(.DIV(DIV_SYS48)) u_sys48 (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .in_tick_i(1'b1), .tick_o(sys48_tick));
  qtc_div #(.DIV(DIV_ALT8)) u_ext8 (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .in_tick_i(ext_osc_tick_i), .tick_o(ext8_tick));
  qtc_div #(.DIV(DIV_ALT8)) u_rtc8 (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .in_tick_i(rtc_tick_i), .tick_o(rtc8_tick));

  // Shared prescaled clock from the two scale bits.
  always_comb begin
    case ({prescale_select_high_i, prescale_select_low_i})
      2'b00:   pre_tick = sys12_tick;
      2'b01:   pre_tick = sys4_tick;
      2'b10:   pre_tick = sys48_tick;
      default: pre_tick = ext8_tick;
    endcase
  end

  // ----------------------------------------------------------------
  // Tick decode for timers 0 and 1
  // ----------------------------------------------------------------
  // Two-sample edge detect; a level held two cycles is always seen.
  assign fall     = st_ff.pin_prev & ~st_ff.pin_smp;
  assign cmp_rise = {comparator_b_output_i, comparator_a_output_i} & ~st_ff.cmp_prev;
  assign t01_cfg  = '{timer_zero_cfg_i, timer_one_cfg_i};
  assign t23_cfg  = '{timer_two_cfg_i, timer_three_cfg_i};

  for (genvar i = 0; i < 2; i++) begin : g_t01
    assign t01_tmr_tick[i] = t01_cfg[i].source_select | pre_tick;
    assign t01_tick[i]     = t01_cfg[i].run &
                             (t01_cfg[i].counter_mode ? fall[i] : t01_tmr_tick[i]);
    assign wr_upper[i]     = sfr_req_i.wr && sfr_req_i.page == SFR_PAGE_TIMER &&
                             sfr_req_i.addr == (i == 0 ? ADDR_T0_UPPER : ADDR_T1_UPPER);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A software write to an upper byte wins over the count in the same cycle.
  always_comb begin
    logic [16:0] s17;
    logic [8:0]  lo9;
    logic [8:0]  hi9;
    logic [7:0]  set;
    logic        t23_tick;
    logic        trig;
    s17      = '0;
    lo9      = '0;
    hi9      = '0;
    set      = '0;
    t23_tick = 1'b0;
    trig     = 1'b0;
    nxt_st          = st_ff;
    nxt_st.pin_smp  = {timer_one_event_pin_i, timer_zero_event_pin_i};
    nxt_st.pin_prev = st_ff.pin_smp;
    nxt_st.cmp_prev = {comparator_b_output_i, comparator_a_output_i};
    // Timers 0 and 1; timer 1 holds its count when asked to split.
    for (int i = 0; i < 2; i++) begin
      if (t01_tick[i] && !(i == 1 && t01_cfg[i].mode == T01_MODE_SPLIT)) begin
        s17             = t01_step(t01_cfg[i].mode, st_ff.t01[i]);
        nxt_st.t01[i]   = s17[15:0];
        set[FLG_T0 + i] = s17[16];
      end
    end
    // Split upper half of timer 0 times timer 0's timer clock path, prescaled or system clock, using timer 1's run bit.
    if (t01_cfg[0].mode == T01_MODE_SPLIT && t01_cfg[1].run && t01_tmr_tick[0]) begin
      nxt_st.t01[0][15:8] = st_ff.t01[0][15:8] + 8'h01;
      set[FLG_T1]         = &st_ff.t01[0][15:8];
    end
    for (int i = 0; i < 2; i++) begin
      if (wr_upper[i]) begin
        nxt_st.t01[i][15:8] = sfr_req_i.wdata;
      end
    end
    // Timers 2 and 3; in capture mode they count system clocks between source events.
    for (int i = 0; i < 2; i++) begin
      case (t23_cfg[i].clk_sel)
        T23_SYS_DIV12: trig = sys12_tick;
        T23_SYS:       trig = 1'b1;
        T23_ALT_DIV8:  trig = (i == 0) ? rtc8_tick : ext8_tick;
        T23_COMP:      trig = cmp_rise[i];
        default:       trig = 1'b0;
      endcase
      t23_tick = t23_cfg[i].run & (t23_cfg[i].capture | trig);
      if (t23_cfg[i].run && t23_cfg[i].capture && trig) begin
        nxt_st.cap[i]         = st_ff.t23[i];
        set[FLG_CAP + i]      = 1'b1;
      end
      if (t23_tick) begin
        lo9 = ar8(st_ff.t23[i][7:0], t23_reload_i[i][7:0]);
        hi9 = ar8(st_ff.t23[i][15:8], t23_reload_i[i][15:8]);
        if (t23_cfg[i].split) begin
          nxt_st.t23[i]             = {hi9[7:0], lo9[7:0]};
          set[FLG_T23_LO + 2 * i]   = lo9[8];
          set[FLG_T23_HI + 2 * i]   = hi9[8];
        end else begin
          nxt_st.t23[i]             = (&st_ff.t23[i]) ? t23_reload_i[i]
                                                      : st_ff.t23[i] + 16'h0001;
          set[FLG_T23_HI + 2 * i]   = &st_ff.t23[i];
        end
      end
    end
    // A flag raised in the cycle it is cleared stays set.
    nxt_st.flag = (st_ff.flag & ~flag_clear_i) | set;
    // Register reads return the value before any same-cycle update.
    nxt_st.rdata = RDATA_UNMAPPED;
    if (sfr_req_i.rd && sfr_req_i.page == SFR_PAGE_TIMER) begin
      if (sfr_req_i.addr == ADDR_T0_UPPER) begin
        nxt_st.rdata = st_ff.t01[0][15:8];
      end else if (sfr_req_i.addr == ADDR_T1_UPPER) begin
        nxt_st.rdata = st_ff.t01[1][15:8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_o   = st_ff.rdata;
  assign flag_o        = st_ff.flag;
  assign t01_count_o   = st_ff.t01;
  assign t23_count_o   = st_ff.t23;
  assign t23_capture_o = st_ff.cap;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_upper0_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_upper[0] |=> t01_count_o[0][15:8] == $past(sfr_req_i.wdata))
    else $error("timer 0 upper byte write lost");
  a_upper1_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sfr_req_i.rd && sfr_req_i.page == SFR_PAGE_TIMER && sfr_req_i.addr == ADDR_T1_UPPER
    |=> sfr_rdata_o == $past(t01_count_o[1][15:8]))
    else $error("timer 1 upper byte read wrong");
  a_pin_fall_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $past(timer_zero_event_pin_i, 2) && !$past(timer_zero_event_pin_i) &&
    timer_zero_cfg_i.run && timer_zero_cfg_i.counter_mode &&
    timer_zero_cfg_i.mode == T01_MODE_16BIT && !wr_upper[0]
    |=> t01_count_o[0] == 16'($past(t01_count_o[0]) + 16'h0001))
    else $error("falling edge on event pin not counted");
  a_no_edge_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !fall[1] && timer_one_cfg_i.counter_mode && !wr_upper[1]
    |=> $stable(t01_count_o[1]))
    else $error("counter moved without an event edge");
  a_sysclk_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    timer_zero_cfg_i.run && !timer_zero_cfg_i.counter_mode &&
    timer_zero_cfg_i.source_select && timer_zero_cfg_i.mode == T01_MODE_16BIT && !wr_upper[0]
    ##1 timer_zero_cfg_i.run && !timer_zero_cfg_i.counter_mode &&
    timer_zero_cfg_i.source_select && timer_zero_cfg_i.mode == T01_MODE_16BIT && !wr_upper[0]
    |=> t01_count_o[0] == 16'($past(t01_count_o[0], 2) + 16'h0002))
    else $error("system clock selection does not count every cycle");
  a_t0_reload: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    t01_tick[0] && timer_zero_cfg_i.mode == T01_MODE_8BIT_RELOAD &&
    t01_count_o[0][7:0] == 8'hFF && !wr_upper[0]
    |=> t01_count_o[0][7:0] == $past(t01_count_o[0][15:8]) && flag_o[FLG_T0])
    else $error("8-bit reload or overflow flag missing");
  a_t1_split_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    timer_one_cfg_i.mode == T01_MODE_SPLIT && !wr_upper[1] |=> $stable(t01_count_o[1]))
    else $error("timer 1 counted in split mode");
  a_t2_reload: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    timer_two_cfg_i.run && !timer_two_cfg_i.split && !timer_two_cfg_i.capture &&
    timer_two_cfg_i.clk_sel == T23_SYS && t23_count_o[0] == 16'hFFFF
    |=> t23_count_o[0] == $past(t23_reload_i[0]) && flag_o[FLG_T23_HI])
    else $error("timer 2 16-bit reload wrong");
  a_t3_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    timer_three_cfg_i.run && timer_three_cfg_i.capture &&
    timer_three_cfg_i.clk_sel == T23_COMP && cmp_rise[1]
    |=> t23_capture_o[1] == $past(t23_count_o[1]) && flag_o[FLG_CAP + 1])
    else $error("timer 3 capture missed");

endmodule

// file: bench/qtc_far_side.sv
`timescale 1ns/1ns
// Model of the event pins, slow clock sources and comparators around the timers.
module qtc_far_side (
  input  wire logic       clk_i,
  input  wire logic [1:0] pin_en_i,
  output logic      [1:0] pin_o,
  output logic            rtc_tick_o,
  output logic            ext_osc_tick_o,
  output logic      [1:0] cmp_o
);
  int phase;

  // ----------------------------------------------------------------
  // Source behaviour
  // ----------------------------------------------------------------
  // Idle pins rest high so that no false fall is seen at start.
  initial begin
    phase          = 0;
    pin_o          = 2'h3;
    rtc_tick_o     = 1'b0;
    ext_osc_tick_o = 1'b0;
    cmp_o          = 2'h0;
  end

  // Each pin level holds two full cycles, the fastest legal rate.
  // A disabled pin only finishes its low level, then rests high.
  always @(negedge clk_i) begin
    phase <= phase + 1;
    for (int i = 0; i < 2; i++) begin
      if (phase[0] && (pin_en_i[i] || !pin_o[i])) begin
        pin_o[i] <= ~pin_o[i];
      end
    end
    rtc_tick_o     <= (phase % 3 == 0);  // One tick every 3 cycles.
    ext_osc_tick_o <= (phase % 5 == 0);  // One tick every 5 cycles.
    if (phase % 4 == 0) begin
      cmp_o <= ~cmp_o;
    end
  end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the timer block.
module tb_top;
  import qtc_pkg::*;
  logic             clk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  qtc_sfr_req_s     req;
  qtc_t01_cfg_s     cfg0, cfg1;
  qtc_t23_cfg_s     cfg2, cfg3;
  logic             ps_hi, ps_lo, rtc, ext;
  logic [1:0]       pin_en, pins, cmp;
  logic [1:0][15:0] reload, t01c, t23c, cap;
  logic [7:0]       fclr, flag, rdata;
  logic [15:0]      v0, v1, cap_a;
  logic [1:0]       pins_q = 2'h3;
  int               falls[2];
  int               fails = 0;
  int               total_checks = 0;
  int               p0[5] = '{192, 64, 768, 640, 16};
  int               p2[4] = '{192, 16, 384, 128};

  qtc_timers dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .timer_zero_cfg_i(cfg0), .timer_one_cfg_i(cfg1), .prescale_select_high_i(ps_hi),
    .prescale_select_low_i(ps_lo), .timer_zero_event_pin_i(pins[0]),
    .timer_one_event_pin_i(pins[1]), .timer_two_cfg_i(cfg2), .timer_three_cfg_i(cfg3),
    .t23_reload_i(reload), .rtc_tick_i(rtc), .ext_osc_tick_i(ext),
    .comparator_a_output_i(cmp[0]), .comparator_b_output_i(cmp[1]), .flag_clear_i(fclr),
    .flag_o(flag), .t01_count_o(t01c), .t23_count_o(t23c), .t23_capture_o(cap));

  qtc_far_side far (.clk_i(clk_i), .pin_en_i(pin_en), .pin_o(pins), .rtc_tick_o(rtc),
    .ext_osc_tick_o(ext), .cmp_o(cmp));

  // ----------------------------------------------------------------
  // Clock, edge counting and watchdog
  // ----------------------------------------------------------------
  // Half period of 10 ns gives the 50 MHz system clock.
  always #10 clk_i = ~clk_i;

  // Falls are counted from the pins themselves, never from the counts.
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) if (pins_q[i] && !pins[i]) falls[i]++;
    pins_q <= pins;
  end

  // The tests need about 20000 cycles; over four times that means a hang.
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A strobe is raised at one falling edge and dropped at the next.
  // One idle edge then passes, so a following call never re-raises it in the same step.
  task automatic sfr(input logic [7:0] pg, input logic [7:0] a, input logic w,
                     input logic [7:0] d, input logic [7:0] exp);
    req = '{page: pg, addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk_i);
    if (!w) chk("sfr read", {8'h00, exp}, {8'h00, rdata});
    req.wr = 1'b0;
    req.rd = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic wait_flag(input int b, output int n);
    n = 0;
    while (flag[b] !== 1'b1 && n < 13000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 13000) chk("flag wait", 16'h0001, 16'h0000);
  endtask

  task automatic clr(input int b);
    fclr[b] = 1'b1;
    @(negedge clk_i);
    fclr[b] = 1'b0;
  endtask

  // Distance between two later flag sets; the first may come from a start value.
  task automatic measure(input int b, input int exp, input logic chk_low);
    int n;
    wait_flag(b, n);
    clr(b);
    wait_flag(b, n);
    cap_a = cap[0];
    clr(b);
    wait_flag(b, n);
    chk("flag period", 16'(exp), 16'(n + 1));
    if (chk_low) chk("low after reload", 16'h00F0, {8'h00, t01c[0][7:0]});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    cfg0 = '0;
    cfg1 = '0;
    cfg2 = '0;
    cfg3 = '0;
    {ps_hi, ps_lo} = 2'h0;
    pin_en = 2'h0;
    reload = '0;
    fclr = 8'h00;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    // Registers: reset values, round trip, refused page and address.
    sfr(8'h00, ADDR_T0_UPPER, 1'b0, 8'h00, 8'h00);
    sfr(8'h00, ADDR_T1_UPPER, 1'b0, 8'h00, 8'h00);
    sfr(8'h00, ADDR_T0_UPPER, 1'b1, 8'hA5, 8'h00);
    sfr(8'h00, ADDR_T1_UPPER, 1'b1, 8'h5A, 8'h00);
    sfr(8'h01, ADDR_T0_UPPER, 1'b1, 8'hFF, 8'h00);
    sfr(8'h00, 8'h8E, 1'b0, 8'h00, 8'h00);
    sfr(8'h00, ADDR_T0_UPPER, 1'b0, 8'h00, 8'hA5);
    sfr(8'h00, ADDR_T1_UPPER, 1'b0, 8'h00, 8'h5A);
    $display("test registers done");
    // Event counting at the fastest legal rate, 16-bit and 13-bit.
    cfg0 = '{run: 1'b1, counter_mode: 1'b1, source_select: 1'b0, mode: T01_MODE_16BIT};
    cfg1 = '{run: 1'b1, counter_mode: 1'b1, source_select: 1'b0, mode: T01_MODE_13BIT};
    falls[0] = 0;
    falls[1] = 0;
    pin_en = 2'h3;
    repeat (40) @(negedge clk_i);
    pin_en = 2'h0;
    repeat (10) @(negedge clk_i);
    chk("timer0 events", 16'hA500 + 16'(falls[0]), t01c[0]);
    chk("timer1 events", 16'h5A00 + 16'(falls[1]), t01c[1]);
    $display("test events done");
    // Timer 0 auto-reload on each of the five clock choices.
    sfr(8'h00, ADDR_T0_UPPER, 1'b1, 8'hF0, 8'h00);
    cfg1.run = 1'b0;
    for (int i = 0; i < 5; i++) begin
      {ps_hi, ps_lo} = 2'(i);
      cfg0 = '{run: 1'b1, counter_mode: 1'b0, source_select: (i == 4),
               mode: T01_MODE_8BIT_RELOAD};
      measure(FLG_T0, p0[i], 1'b1);
    end
    $display("test prescale done");
    // Timer 0 as a 16-bit timer on the undivided system clock.
    cfg0 = '{run: 1'b1, counter_mode: 1'b0, source_select: 1'b1, mode: T01_MODE_16BIT};
    v0 = t01c[0];
    repeat (20) @(negedge clk_i);
    chk("timer0 sysclk", v0 + 16'h0014, t01c[0]);
    $display("test system clock done");
    // Timer 0 splits into two byte counters; timer 1 holds but lends its run bit.
    cfg0.mode = T01_MODE_SPLIT;
    cfg1 = '{run: 1'b1, counter_mode: 1'b0, source_select: 1'b1, mode: T01_MODE_SPLIT};
    v0 = t01c[0];
    v1 = t01c[1];
    repeat (20) @(negedge clk_i);
    chk("timer0 split", {v0[15:8] + 8'h14, v0[7:0] + 8'h14}, t01c[0]);
    chk("timer1 split hold", v1, t01c[1]);
    $display("test split hold done");
    // Timers 2 and 3 in split mode on every clock choice.
    reload = {16'hF0F0, 16'hF0F0};
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 4; s++) begin
        cfg2 = '{run: (t == 0), split: 1'b1, capture: 1'b0, clk_sel: qtc_t23_clk_e'(s)};
        cfg3 = '{run: (t == 1), split: 1'b1, capture: 1'b0, clk_sel: qtc_t23_clk_e'(s)};
        measure(FLG_T23_LO + 2 * t, (t == 1 && s == 2) ? 640 : p2[s], 1'b0);
      end
    end
    $display("test auto reload done");
    // Timer 2 as one 16-bit auto-reload timer; 256 counts from the reload to rollover.
    reload[0] = 16'hFF00;
    cfg3.run = 1'b0;
    cfg2 = '{run: 1'b1, split: 1'b0, capture: 1'b0, clk_sel: T23_SYS};
    measure(FLG_T23_HI, 256, 1'b0);
    chk("timer2 reload", 16'hFF00, t23c[0]);
    $display("test timer2 16-bit done");
    // Capture of the comparator period against the system clock, on both timers.
    reload = '0;
    cfg2 = '{run: 1'b1, split: 1'b0, capture: 1'b1, clk_sel: T23_COMP};
    cfg3 = cfg2;
    measure(FLG_CAP, 8, 1'b0);
    v0 = cap[0] - cap_a;
    chk("capture span", 16'h0008, v0);
    chk("timer3 capture flag", 16'h0001, 16'(flag[FLG_CAP + 1]));
    $display("test capture done");
    stop_test();
  end
endmodule
